/* File: inc/gpmux_pkg.sv */
// shared constants and carrier types for the gpio alternate-function mux
package gpmux_pkg;
  localparam int          NPORT      = 3;
  localparam int          NREG       = 12;
  localparam int          NPIN       = NPORT * 8;
  // register word index inside one port window
  localparam logic [3:0]  REG_IN     = 4'h0; // synchronised pin levels, read only
  localparam logic [3:0]  REG_OUT    = 4'h1; // output data
  localparam logic [3:0]  REG_DIR    = 4'h2; // data direction, 1 = input
  localparam logic [3:0]  REG_AF     = 4'h3; // alt_function_enable
  localparam logic [3:0]  REG_SEL_LO = 4'h4; // alt_select_low
  localparam logic [3:0]  REG_SEL_HI = 4'h5; // alt_select_high
  localparam logic [3:0]  REG_OD     = 4'h6; // open-drain enable
  localparam logic [3:0]  REG_DRV    = 4'h7; // high drive current
  localparam logic [3:0]  REG_PU     = 4'h8; // pull-up enable
  localparam logic [3:0]  REG_WAKE   = 4'h9; // stop-mode wake-up enable
  localparam logic [3:0]  REG_LED_EN = 4'ha; // led drive enable, port c only
  localparam logic [3:0]  REG_LED_LV = 4'hb; // led drive level, port c only
  localparam logic [1:0]  PORT_LED   = 2'h2;
  localparam int          LED_LV_W   = 2;
  localparam logic [7:0]  DIR_RST    = 8'hff;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  // select pair {alt_select_low, alt_select_high}
  localparam logic [1:0]  SEL_00     = 2'h0;
  localparam logic [1:0]  SEL_01     = 2'h1;
  localparam logic [1:0]  SEL_10     = 2'h2;
  localparam logic [1:0]  SEL_11     = 2'h3;

  typedef struct packed {
    logic timer0_output;
    logic timer0_output_comp;
    logic timer0_comp_mode;
    logic timer1_output;
    logic timer1_output_comp;
    logic timer1_comp_mode;
    logic uart_transmit_data;
    logic infrared_transmit_data;
    logic infrared_mode;
    logic uart_driver_enable;
    logic comparator_output;
  } gpmux_drive_t;

  typedef struct packed {
    logic timer0_input;
    logic timer1_input;
    logic uart_receive_data;
    logic infrared_receive_data;
    logic uart_clear_to_send;
    logic external_clock_input;
    logic ext_reset_n;
  } gpmux_sense_t;
endpackage

/* File: hdl/gpmux_top.sv */
// gpio port control and alternate-function pin multiplexer with apb registers
`timescale 1ns/1ns
// Behaviour
// - 24 pins, three ports, each pin independent
// - per-pin direction, drain, drive, pull, wake, function
// - port c pins drive leds, level selectable
// - alternate function owns pin direction
// - low and high select bits pick function
// - crystal enable takes over port a bits 0,1
// - timer mode picks input or complement output
// - six-pin bits 0,1 select map
// - six-pin bit 2 select map
// - six-pin bit 3 select map
// - six-pin bits 4,5 select map
// - analog functions need the function enable
// - eight-pin timer pins fixed functions
// - eight-pin uart pins fixed functions
// - eight-pin enable connects single function directly
module gpmux_top #(
  parameter bit SIX_PIN_PORT_A = 1'b0        // 1: six-pin port a select map
) (
  input  wire logic                            pclk,           // system clock
  input  wire logic                            presetn,        // async reset, low
  input  wire logic                            psel,           // apb select
  input  wire logic                            penable,        // apb enable
  input  wire logic                            pwrite,         // apb direction
  input  wire logic [11:0]                     paddr,          // apb byte address
  input  wire logic [31:0]                     pwdata,         // apb write data
  output logic      [31:0]                     prdata,         // apb read data
  output logic                                 pready,         // apb ready
  output logic                                 pslverr,        // apb error
  input  wire logic [gpmux_pkg::NPIN-1:0]      pad_in,         // pad levels
  output logic      [gpmux_pkg::NPIN-1:0]      pad_out,        // pad drive value
  output logic      [gpmux_pkg::NPIN-1:0]      pad_oe,         // pad driver on
  output logic      [gpmux_pkg::NPIN-1:0]      pad_high_drive, // strong drive
  output logic      [gpmux_pkg::NPIN-1:0]      pad_pull_up,    // pull-up on
  output logic      [gpmux_pkg::NPIN-1:0]      pad_stop_wake,  // wake source
  output logic      [gpmux_pkg::NPIN-1:0]      pad_analog,     // analog switch
  output logic      [7:0]                      led_drive,      // port c led on
  output logic      [gpmux_pkg::LED_LV_W-1:0]  led_level,      // led current
  input  wire logic                            xtal_enable,    // oscillator on
  input  wire gpmux_pkg::gpmux_drive_t         periph_drive,   // from peripherals
  output gpmux_pkg::gpmux_sense_t              periph_sense    // to peripherals
);
  import gpmux_pkg::*;

  logic [7:0]      cfg       [NPORT][NREG];
  logic [7:0]      next_cfg  [NPORT][NREG];
  logic [31:0]     next_prdata;
  logic            next_pready;
  logic            next_pslverr;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [1:0]      sel_port;
  logic [3:0]      sel_reg;
  logic            hit;
  logic [NPIN-1:0] dout_v, dir_v, af_v, sl_v, sh_v, od_v, drv_v, pu_v, wk_v;

  // flatten per-port registers into per-pin vectors
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      dout_v[p*8 +: 8] = cfg[p][REG_OUT];
      dir_v[p*8 +: 8]  = cfg[p][REG_DIR];
      af_v[p*8 +: 8]   = cfg[p][REG_AF];
      sl_v[p*8 +: 8]   = cfg[p][REG_SEL_LO];
      sh_v[p*8 +: 8]   = cfg[p][REG_SEL_HI];
      od_v[p*8 +: 8]   = cfg[p][REG_OD];
      drv_v[p*8 +: 8]  = cfg[p][REG_DRV];
      pu_v[p*8 +: 8]   = cfg[p][REG_PU];
      wk_v[p*8 +: 8]   = cfg[p][REG_WAKE];
    end
  end

  // apb slave: answer in the first access cycle, writes land at that edge
  always_comb begin
    sel_port     = paddr[7:6];
    sel_reg      = paddr[5:2];
    hit          = (paddr[1:0] == 2'h0) && (paddr[11:8] == 4'h0) &&
                   (sel_port < 2'(NPORT)) && (sel_reg < 4'(NREG)) &&
                   (sel_reg < REG_LED_EN || sel_port == PORT_LED);
    next_cfg     = cfg;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    if (psel && !penable && !pready) begin
      next_pready  = 1'b1;
      next_pslverr = !hit;
      next_prdata  = 32'h0;
      if (hit && sel_reg == REG_IN) begin
        next_prdata[7:0] = pin_sync[sel_port*8 +: 8];
      end else if (hit) begin
        next_prdata[7:0] = cfg[sel_port][sel_reg];
      end
    end
    // the whole register byte is written at once from pwdata[7:0]
    if (psel && penable && pready && pwrite && hit && sel_reg != REG_IN) begin
      next_cfg[sel_port][sel_reg] = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int r = 0; r < NREG; r++) begin
          cfg[p][r] <= (r == int'(REG_DIR)) ? DIR_RST : CFG_RST;
        end
      end
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // two-stage synchroniser; only pin_sync is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pad_in;
      pin_sync <= pin_meta;
    end
  end

  // port a alternate function map; ports b and c only offer analog use here
  logic [NPIN-1:0] alt_oe, alt_out, alt_ana;
  logic [1:0]      code [8];
  gpmux_sense_t    next_sense;
  logic            txd;

  always_comb begin
    alt_oe  = '0;
    alt_out = '0;
    alt_ana = '0;
    for (int i = 0; i < 8; i++) begin
      code[i] = {sl_v[i], sh_v[i]};
    end
    for (int i = 8; i < NPIN; i++) begin
      alt_ana[i] = sl_v[i];
    end
    txd = periph_drive.infrared_mode ? periph_drive.infrared_transmit_data
                                     : periph_drive.uart_transmit_data;
    next_sense = '{timer0_input: 1'b0, timer1_input: 1'b0,
                   uart_receive_data: 1'b1, infrared_receive_data: 1'b1,
                   uart_clear_to_send: 1'b0, external_clock_input: 1'b0,
                   ext_reset_n: 1'b1};
    if (SIX_PIN_PORT_A) begin
      // unlisted codes fall through: no peripheral, driver stays off; on pin 3 the default is analog
      case (code[0])
        SEL_00:  next_sense.timer0_input = af_v[0] ? pin_sync[0] : 1'b0;
        SEL_11:  begin
          alt_oe[0]  = 1'b1;
          alt_out[0] = periph_drive.timer0_output_comp;
        end
        default: alt_oe[0] = 1'b0;
      endcase
      case (code[1])
        SEL_00:  begin
          alt_oe[1]  = 1'b1;
          alt_out[1] = periph_drive.timer0_output;
        end
        SEL_10:  next_sense.external_clock_input = af_v[1] ? pin_sync[1] : 1'b0;
        SEL_11:  alt_ana[1] = 1'b1;
        default: alt_oe[1] = 1'b0;
      endcase
      case (code[2])
        SEL_00:  begin
          alt_oe[2]  = 1'b1;
          alt_out[2] = periph_drive.uart_driver_enable;
        end
        SEL_01:  next_sense.ext_reset_n = af_v[2] ? pin_sync[2] : 1'b1;
        SEL_10:  begin
          alt_oe[2]  = 1'b1;
          alt_out[2] = periph_drive.timer1_output;
        end
        default: alt_oe[2] = 1'b0;
      endcase
      case (code[3])
        SEL_00:  next_sense.uart_clear_to_send = af_v[3] ? pin_sync[3] : 1'b0;
        SEL_01:  begin
          alt_oe[3]  = 1'b1;
          alt_out[3] = periph_drive.comparator_output;
        end
        SEL_10:  next_sense.timer1_input = af_v[3] ? pin_sync[3] : 1'b0;
        default: alt_ana[3] = 1'b1;
      endcase
      case (code[4])
        SEL_00:  next_sense.uart_receive_data = af_v[4] ? pin_sync[4] : 1'b1;
        SEL_11:  alt_ana[4] = 1'b1;
        default: alt_oe[4] = 1'b0;
      endcase
      case (code[5])
        SEL_00:  begin
          alt_oe[5]  = 1'b1;
          alt_out[5] = txd;
        end
        SEL_01:  begin
          alt_oe[5]  = 1'b1;
          alt_out[5] = periph_drive.timer1_output_comp;
        end
        SEL_11:  alt_ana[5] = 1'b1;
        default: alt_oe[5] = 1'b0;
      endcase
      if (af_v[4] && code[4] == SEL_00) begin
        next_sense.infrared_receive_data = pin_sync[4];
      end
    end else begin
      // one function per pin, the enable connects it; on pins 0 and 6 the timer mode also picks input or complement output
      alt_oe[0]  = periph_drive.timer0_comp_mode;
      alt_out[0] = periph_drive.timer0_output_comp;
      alt_oe[1]  = 1'b1;
      alt_out[1] = periph_drive.timer0_output;
      alt_oe[2]  = 1'b1;
      alt_out[2] = periph_drive.uart_driver_enable;
      alt_oe[5]  = 1'b1;
      alt_out[5] = txd;
      alt_oe[6]  = periph_drive.timer1_comp_mode;
      alt_out[6] = periph_drive.timer1_output_comp;
      alt_oe[7]  = 1'b1;
      alt_out[7] = periph_drive.timer1_output;
      if (af_v[0] && !periph_drive.timer0_comp_mode) begin
        next_sense.timer0_input = pin_sync[0];
      end
      if (af_v[6] && !periph_drive.timer1_comp_mode) begin
        next_sense.timer1_input = pin_sync[6];
      end
      if (af_v[3]) begin
        next_sense.uart_clear_to_send = pin_sync[3];
      end
      if (af_v[4]) begin
        next_sense.uart_receive_data     = pin_sync[4];
        next_sense.infrared_receive_data = pin_sync[4];
      end
    end
  end

  // per-pin final stage: oscillator, alternate function or plain gpio
  logic [NPIN-1:0] next_pad_out, next_pad_oe, next_pad_analog;
  logic [NPIN-1:0] next_pad_pull, next_pad_wake;
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      logic xt;
      logic raw_oe;
      logic raw_out;
      assign xt      = xtal_enable && (g < 2);
      assign raw_oe  = xt ? 1'b0 : af_v[g] ? alt_oe[g] : !dir_v[g];
      assign raw_out = af_v[g] ? alt_out[g] : dout_v[g];
      // open drain only releases a high, never drives it
      assign next_pad_oe[g]     = raw_oe && !(od_v[g] && raw_out);
      assign next_pad_out[g]    = raw_out && !xt;
      assign next_pad_analog[g] = af_v[g] && alt_ana[g] && !xt;
      assign next_pad_pull[g]   = pu_v[g] && !xt;
      assign next_pad_wake[g]   = wk_v[g] && !xt;
    end
  endgenerate

  // pin outputs registered so pads never see decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out        <= '0;
      pad_oe         <= '0;
      pad_high_drive <= '0;
      pad_pull_up    <= '0;
      pad_stop_wake  <= '0;
      pad_analog     <= '0;
      led_drive      <= 8'h00;
      led_level      <= '0;
      periph_sense   <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    end else begin
      pad_out        <= next_pad_out;
      pad_oe         <= next_pad_oe;
      pad_high_drive <= drv_v;
      pad_pull_up    <= next_pad_pull;
      pad_stop_wake  <= next_pad_wake;
      pad_analog     <= next_pad_analog;
      led_drive      <= cfg[PORT_LED][REG_LED_EN];
      led_level      <= cfg[PORT_LED][REG_LED_LV][LED_LV_W-1:0];
      periph_sense   <= next_sense;
    end
  end

  a_xtal_override: assert property (@(posedge pclk) disable iff (!presetn)
    xtal_enable |=> !pad_oe[0] && !pad_oe[1] && !pad_analog[1])
    else $error("crystal pins still driven");

  a_gpio_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pwrite && paddr == 12'h048 && !pwdata[0] &&
    !af_v[8] && !od_v[8] |=> ##1 pad_oe[8])
    else $error("direction write did not enable port b pin 0 driver");

  a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
    SIX_PIN_PORT_A && af_v[4] && {sl_v[4], sh_v[4]} == SEL_01
    |=> !pad_oe[4] && !pad_analog[4])
    else $error("reserved code drove pin a4");

  a_alt_owns_dir: assert property (@(posedge pclk) disable iff (!presetn)
    af_v[1] && dir_v[1] && !xtal_enable && !od_v[1] &&
    (!SIX_PIN_PORT_A || {sl_v[1], sh_v[1]} == SEL_00)
    |=> pad_oe[1] && pad_out[1] == $past(periph_drive.timer0_output))
    else $error("timer 0 output not on pin a1");

  a_timer_mode_pick: assert property (@(posedge pclk) disable iff (!presetn)
    !SIX_PIN_PORT_A && af_v[0] && !xtal_enable && !od_v[0]
    |=> pad_oe[0] == $past(periph_drive.timer0_comp_mode))
    else $error("pin a0 direction ignores timer mode");

  a_analog_gate: assert property (@(posedge pclk) disable iff (!presetn)
    pad_analog[3] |-> $past(af_v[3]))
    else $error("analog switch without function enable");

  a_led_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(led_drive[2]) |-> $past(cfg[PORT_LED][REG_LED_EN][2]))
    else $error("led drive without enable");

  a_rx_route: assert property (@(posedge pclk) disable iff (!presetn)
    af_v[4] && (!SIX_PIN_PORT_A || {sl_v[4], sh_v[4]} == SEL_00)
    |=> periph_sense.uart_receive_data == $past(pin_sync[4]))
    else $error("receive data not routed from pin a4");

  a_single_func: assert property (@(posedge pclk) disable iff (!presetn)
    !SIX_PIN_PORT_A && af_v[7] && !od_v[7]
    |=> pad_oe[7] && pad_out[7] == $past(periph_drive.timer1_output))
    else $error("timer 1 output not on pin a7");

  a_clock_select: assert property (@(posedge pclk) disable iff (!presetn)
    SIX_PIN_PORT_A && af_v[1] && {sl_v[1], sh_v[1]} == SEL_10
    |=> !pad_oe[1] && periph_sense.external_clock_input == $past(pin_sync[1]))
    else $error("clock input select wrong on pin a1");

  a_reset_select: assert property (@(posedge pclk) disable iff (!presetn)
    SIX_PIN_PORT_A && af_v[2] && {sl_v[2], sh_v[2]} == SEL_01
    |=> !pad_oe[2] && periph_sense.ext_reset_n == $past(pin_sync[2]))
    else $error("reset input select wrong on pin a2");

  a_comp_select: assert property (@(posedge pclk) disable iff (!presetn)
    SIX_PIN_PORT_A && af_v[3] && !od_v[3] && {sl_v[3], sh_v[3]} == SEL_01
    |=> pad_oe[3] && pad_out[3] == $past(periph_drive.comparator_output))
    else $error("comparator output not on pin a3");

  a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
endmodule

/* File: tb/gpmux_board_model.sv */
// board-side model of the pads: resolves each pin from device, board source and pull-up
`timescale 1ns/1ns
module gpmux_board_model (
  input  wire logic                       pclk,        // system clock
  input  wire logic [gpmux_pkg::NPIN-1:0] pad_out,     // device drive value
  input  wire logic [gpmux_pkg::NPIN-1:0] pad_oe,      // device driver on
  input  wire logic [gpmux_pkg::NPIN-1:0] pad_pull_up, // device pull-up on
  input  wire logic [gpmux_pkg::NPIN-1:0] board_level, // board source level
  input  wire logic [gpmux_pkg::NPIN-1:0] board_en,    // board source on
  output logic      [gpmux_pkg::NPIN-1:0] pad_in       // resolved pin level
);
  import gpmux_pkg::*;
  logic float_pat = 1'b0;
  // a floating pin wanders each cycle so a stale level never passes for a driven one
  always @(posedge pclk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (board_en[i])
        pad_in[i] = board_level[i];
      else if (pad_pull_up[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = float_pat;
    end
  end
endmodule

/* File: tb/gpmux_top_tb.sv */
// self-checking bench for the gpio alternate-function mux, both port a maps
`timescale 1ns/1ns
module gpmux_top_tb;
  import gpmux_pkg::*;
  logic          pclk        = 1'b0;
  logic          presetn     = 1'b0;
  logic          psel        = 1'b0;
  logic          penable     = 1'b0;
  logic          pwrite      = 1'b0;
  logic [11:0]   paddr       = 12'h000;
  logic [31:0]   pwdata      = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [23:0]   pad_in;
  logic [23:0]   pad_out;
  logic [23:0]   pad_oe;
  logic [23:0]   pad_high_drive;
  logic [23:0]   pad_pull_up;
  logic [23:0]   pad_stop_wake;
  logic [23:0]   pad_analog;
  logic [7:0]    led_drive;
  logic [1:0]    led_level;
  logic          xtal_enable  = 1'b0;
  gpmux_drive_t  periph_drive = '0;
  gpmux_sense_t  periph_sense;
  logic [23:0]   pad_oe8;
  logic [23:0]   pad_out8;
  gpmux_sense_t  periph_sense8;
  logic [7:0]    m8;
  logic [23:0]   board_level  = 24'h00005a;
  logic [23:0]   board_en     = 24'hffffff;
  logic          v1;
  logic          cm;
  int            fails        = 0;
  int            comparisons  = 0;
  // per select code: driven pins, analog pins, sense word with every input pin at 1
  logic [5:0]    oe_tab [4]   = '{6'h26, 6'h28, 6'h04, 6'h01};
  logic [5:0]    an_tab [4]   = '{6'h00, 6'h00, 6'h00, 6'h3a};
  logic [6:0]    se_tab [4]   = '{7'h5d, 7'h19, 7'h3b, 7'h19};

  always #5 pclk = ~pclk;

  gpmux_top #(.SIX_PIN_PORT_A(1'b1)) gpmux_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_high_drive(pad_high_drive),
    .pad_pull_up(pad_pull_up), .pad_stop_wake(pad_stop_wake), .pad_analog(pad_analog),
    .led_drive(led_drive), .led_level(led_level), .xtal_enable(xtal_enable),
    .periph_drive(periph_drive), .periph_sense(periph_sense)
  );

  gpmux_board_model gpmux_board_model_inst (
    .pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .board_level(board_level), .board_en(board_en), .pad_in(pad_in)
  );

  // eight-pin map: shares bus, pad inputs and peripherals, so writes land in both
  gpmux_top #(.SIX_PIN_PORT_A(1'b0)) gpmux_top_inst8 (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .pad_in(pad_in), .pad_out(pad_out8), .pad_oe(pad_oe8), .pad_high_drive(),
    .pad_pull_up(), .pad_stop_wake(), .pad_analog(), .led_drive(), .led_level(),
    .xtal_enable(xtal_enable), .periph_drive(periph_drive), .periph_sense(periph_sense8)
  );

  task automatic end_of_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // no answer in bound: count it and stop here rather than hang
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk(32'(err), 32'h0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(experr));
  endtask

  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    chk(32'(pad_oe), 32'h0);
    rdc(12'h008, 32'(DIR_RST), 1'b0);
    rdc(12'h00c, 32'(CFG_RST), 1'b0);
    rdc(12'h000, 32'h5a, 1'b0);
    rdc(12'h100, 32'h0, 1'b1);
    rdc(12'h028, 32'h0, 1'b1);
    @(posedge pclk);
    board_en <= '0;
    wr(12'h004, 32'ha5);
    wr(12'h008, 32'h00);
    wr(12'h018, 32'h01);
    wr(12'h020, 32'h0f);
    wr(12'h01c, 32'h33);
    wr(12'h024, 32'h3c);
    wr(12'h044, 32'h5a);
    wr(12'h048, 32'h00);
    wr(12'h0a8, 32'hc3);
    wr(12'h0ac, 32'h02);
    settle(3);
    chk(32'(pad_oe), 32'h00fffe);
    chk(32'(pad_out[15:1]), {17'h0, 8'h5a, 7'h52});
    chk(32'(pad_pull_up), 32'h0f);
    chk(32'(pad_high_drive), 32'h33);
    chk(32'(pad_stop_wake), 32'h3c);
    chk(32'(led_drive), 32'hc3);
    chk(32'(led_level), 32'h2);
    // bit 0 released by open drain, held high only by its pull-up
    rdc(12'h000, 32'ha5, 1'b0);
    wr(12'h018, 32'h00);
    @(posedge pclk);
    board_en <= '1;
    board_level <= '1;
    for (int c = 0; c < 4; c++) begin
      for (int v = 0; v < 2; v++) begin
        v1 = v[0];
        cm = (c == 3);
        m8 = {1'b1, cm, 1'b1, 2'b00, 2'b11, cm};
        wr(12'h00c, 32'h00);
        wr(12'h010, {26'h0, {6{c[1]}}});
        wr(12'h014, {26'h0, {6{c[0]}}});
        @(posedge pclk);
        // infrared mode follows cm; uart data inverted then, so a wrong pick shows
        periph_drive <= gpmux_drive_t'({v1, v1, cm, v1, v1, cm, v1 ^ cm, v1, cm, v1, v1});
        settle(2);
        chk(32'(pad_analog[5:0]), 32'h0);
        chk(32'(pad_oe[5:0]), 32'h3f);
        wr(12'h00c, 32'hff);
        settle(6);
        chk(32'(pad_oe[5:0]), 32'(oe_tab[c]));
        chk(32'(pad_out[5:0] & oe_tab[c]), 32'({6{v1}} & oe_tab[c]));
        chk(32'(pad_analog[5:0]), 32'(an_tab[c]));
        chk(32'(periph_sense), 32'(se_tab[c]));
        chk(32'(pad_oe8[7:0]), 32'(m8));
        chk(32'(pad_out8[7:0] & m8), 32'({8{v1}} & m8));
        chk(32'(periph_sense8), 32'({~cm, ~cm, 2'b11, ((c == 1) ? v1 : 1'b1), 2'b01}));
      end
    end
    wr(12'h010, 32'h00);
    wr(12'h014, 32'h00);
    // direction says input, yet the function still drives pin a1
    wr(12'h008, 32'hff);
    settle(2);
    chk(32'(pad_oe[1:0]), 32'h2);
    @(posedge pclk);
    xtal_enable <= 1'b1;
    settle(2);
    chk(32'(pad_oe[1:0]), 32'h0);
    chk(32'(pad_oe8[1:0]), 32'h0);
    chk(32'(pad_pull_up[1:0]), 32'h0);
    @(posedge pclk);
    xtal_enable <= 1'b0;
    settle(2);
    chk(32'(pad_oe[1:0]), 32'h2);
    end_of_test();
  end
endmodule
